// ---- hw/spi_pin_sel.sv ----
// Serial port pins, select line modes, master and slave shifting.
// Assumes pins are asynchronous; system clock at 200 MHz; mode 0 clocking.
`include "spi_pins_defines.svh"
`default_nettype none

module spi_pin_sel (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       sys_rst_i,
   // Register port
   input  wire logic [3:0] addr_i,
   input  wire logic [7:0] wdata_i,
   input  wire logic       wr_i,
   input  wire logic       rd_i,
   output logic      [7:0] rdata_o,
   // Data out (master to slave) pin
   input  wire logic       mosi_i,
   output logic            mosi_o,
   output logic            mosi_oe_n_o,
   // Data in (slave to master) pin
   input  wire logic       miso_i,
   output logic            miso_o,
   output logic            miso_oe_n_o,
   // Serial clock pin
   input  wire logic       sck_i,
   output logic            sck_o,
   output logic            sck_oe_n_o,
   // Select pin
   input  wire logic       nss_i,
   output logic            nss_o,
   output logic            nss_oe_n_o,
   output logic            nss_routed_o
);

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   logic [1:0] sck_s_r, nss_s_r, mosi_s_r, miso_s_r;
   logic       sck_d_r, nss_d_r;

   // Two stages each, then one delay on clock and select for edge finding
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         sck_s_r  <= 2'h0;
         nss_s_r  <= 2'h3;
         mosi_s_r <= 2'h0;
         miso_s_r <= 2'h0;
         sck_d_r  <= 1'b0;
         nss_d_r  <= 1'b1;
      end else begin
         sck_s_r  <= {sck_s_r[0], sck_i};
         nss_s_r  <= {nss_s_r[0], nss_i};
         mosi_s_r <= {mosi_s_r[0], mosi_i};
         miso_s_r <= {miso_s_r[0], miso_i};
         sck_d_r  <= sck_s_r[1];
         nss_d_r  <= nss_s_r[1];
      end
   end

   logic sck_rise, sck_fall, nss_fall, nss_lvl;
   assign sck_rise = sck_s_r[1] & ~sck_d_r;
   assign sck_fall = ~sck_s_r[1] & sck_d_r;
   assign nss_fall = ~nss_s_r[1] & nss_d_r;
   assign nss_lvl  = nss_s_r[1];

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   logic [7:0] ctrl_r, ctrl_nxt;
   logic [7:0] div_r, div_nxt;
   logic [7:0] shreg_r, shreg_nxt;
   logic [7:0] rxbuf_r, rxbuf_nxt;
   logic [7:0] rdata_r, rdata_nxt;
   logic [7:0] dcnt_r, dcnt_nxt;
   logic [3:0] bcnt_r, bcnt_nxt;
   logic       sck_r, sck_nxt;
   logic       samp_r, samp_nxt;
   spi_pins_pkg::mst_state_t mst_r, mst_nxt;

   logic       en, master;
   spi_pins_pkg::sel_mode_t selm;
   logic       selected, slave_act;
   assign en     = ctrl_r[`CTRL_EN_BIT];
   assign master = ctrl_r[`CTRL_MASTER_ENABLE_BIT_BIT];
   assign selm   = spi_pins_pkg::sel_mode_t'(
      {ctrl_r[`CTRL_SELHI_BIT], ctrl_r[`CTRL_SELLO_BIT]});
   // 3-wire slave always selected; 4-wire slave needs select low
   assign selected = (selm == `SEL_3WIRE) | ~nss_lvl;
   // Slave logic acts only when enabled, not master, and selected
   assign slave_act = en & ~master & selected;

   // Next state of control, shifting and counting
   always_comb begin
      ctrl_nxt  = ctrl_r;
      div_nxt   = div_r;
      shreg_nxt = shreg_r;
      rxbuf_nxt = rxbuf_r;
      rdata_nxt = 8'h00;
      dcnt_nxt  = dcnt_r;
      bcnt_nxt  = bcnt_r;
      sck_nxt   = sck_r;
      samp_nxt  = samp_r;
      mst_nxt   = mst_r;
      // Software writes
      if (wr_i) begin
         case (addr_i)
            `ADDR_CTRL: begin
               ctrl_nxt[`CTRL_EN_BIT]    = wdata_i[`CTRL_EN_BIT];
               ctrl_nxt[`CTRL_SELLO_BIT] = wdata_i[`CTRL_SELLO_BIT];
               ctrl_nxt[`CTRL_SELHI_BIT] = wdata_i[`CTRL_SELHI_BIT];
               ctrl_nxt[`CTRL_MASTER_ENABLE_BIT_BIT] = wdata_i[`CTRL_MASTER_ENABLE_BIT_BIT];
               // Flags clear on writing zero
               if (!wdata_i[`CTRL_MODE_FAULT_FLAG_BIT])
                  ctrl_nxt[`CTRL_MODE_FAULT_FLAG_BIT] = 1'b0;
               if (!wdata_i[`CTRL_DONE_BIT])
                  ctrl_nxt[`CTRL_DONE_BIT] = 1'b0;
               // Re-enable clears the bit counter
               if (wdata_i[`CTRL_EN_BIT] && !en)
                  bcnt_nxt = 4'h0;
            end
            `ADDR_DATA: begin
               shreg_nxt = wdata_i;
               if (en && master && mst_r == spi_pins_pkg::M_IDLE) begin
                  mst_nxt  = spi_pins_pkg::M_BUSY;
                  bcnt_nxt = 4'h0;
                  dcnt_nxt = div_r;
                  sck_nxt  = 1'b0;
               end
            end
            `ADDR_CLKDIV: div_nxt = wdata_i;
            default: ;
         endcase
      end
      // Read data, one cycle later
      if (rd_i) begin
         case (addr_i)
            `ADDR_CTRL:   rdata_nxt = ctrl_r;
            `ADDR_DATA:   rdata_nxt = rxbuf_r;
            `ADDR_CLKDIV: rdata_nxt = div_r;
            default:      rdata_nxt = 8'h00;
         endcase
      end
      // Master clock generation and shifting
      if (mst_r == spi_pins_pkg::M_BUSY) begin
         if (dcnt_r != 8'h00) begin
            dcnt_nxt = dcnt_r - 8'h01;
         end else begin
            dcnt_nxt = div_r;
            sck_nxt  = ~sck_r;
            if (!sck_r) begin
               samp_nxt = miso_s_r[1];
            end else begin
               shreg_nxt = {shreg_r[6:0], samp_r};
               bcnt_nxt  = bcnt_r + 4'h1;
               if (bcnt_r == `BITS_PER_BYTE - 4'h1) begin
                  mst_nxt   = spi_pins_pkg::M_IDLE;
                  rxbuf_nxt = {shreg_r[6:0], samp_r};
                  ctrl_nxt[`CTRL_DONE_BIT] = 1'b1;
                  bcnt_nxt  = 4'h0;
               end
            end
         end
      end
      // Slave shifting on serial clock edges
      if (en && !master && selm == `SEL_4WIRE_IN && nss_fall)
         bcnt_nxt = 4'h0;
      else if (slave_act && sck_rise)
         samp_nxt = mosi_s_r[1];
      else if (slave_act && sck_fall) begin
         shreg_nxt = {shreg_r[6:0], samp_r};
         bcnt_nxt  = bcnt_r + 4'h1;
         if (bcnt_r == `BITS_PER_BYTE - 4'h1) begin
            rxbuf_nxt = {shreg_r[6:0], samp_r};
            ctrl_nxt[`CTRL_DONE_BIT] = 1'b1;
            bcnt_nxt  = 4'h0;
         end
      end
      // Mode fault: another master pulled select low
      if (en && master && selm == `SEL_4WIRE_IN && nss_fall) begin
         ctrl_nxt[`CTRL_MASTER_ENABLE_BIT_BIT] = 1'b0;
         ctrl_nxt[`CTRL_EN_BIT]    = 1'b0;
         ctrl_nxt[`CTRL_MODE_FAULT_FLAG_BIT]  = 1'b1;
      end
      // Disabled port or slave role idles the master and drops its clock
      if (!ctrl_nxt[`CTRL_EN_BIT] || !ctrl_nxt[`CTRL_MASTER_ENABLE_BIT_BIT]) begin
         mst_nxt = spi_pins_pkg::M_IDLE;
         sck_nxt = 1'b0;
      end
   end

   // Register state
   always_ff @(posedge clk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         ctrl_r  <= `CTRL_RESET;
         div_r   <= `CLKDIV_RESET;
         shreg_r <= 8'h00;
         rxbuf_r <= 8'h00;
         rdata_r <= 8'h00;
         dcnt_r  <= 8'h00;
         bcnt_r  <= 4'h0;
         sck_r   <= 1'b0;
         samp_r  <= 1'b0;
         mst_r   <= spi_pins_pkg::M_IDLE;
      end else begin
         ctrl_r  <= ctrl_nxt;
         div_r   <= div_nxt;
         shreg_r <= shreg_nxt;
         rxbuf_r <= rxbuf_nxt;
         rdata_r <= rdata_nxt;
         dcnt_r  <= dcnt_nxt;
         bcnt_r  <= bcnt_nxt;
         sck_r   <= sck_nxt;
         samp_r  <= samp_nxt;
         mst_r   <= mst_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Pin drivers (enable low means driving)
   // ----------------------------------------------------------------
   assign rdata_o     = rdata_r;
   assign mosi_o      = shreg_r[7];
   assign mosi_oe_n_o = ~(en & master);
   assign miso_o      = shreg_r[7];
   assign miso_oe_n_o = ~slave_act | master;
   assign sck_o       = sck_r;
   assign sck_oe_n_o  = ~(en & master);
   assign nss_o       = ctrl_r[`CTRL_SELLO_BIT];
   assign nss_oe_n_o  = ~ctrl_r[`CTRL_SELHI_BIT];
   assign nss_routed_o = (selm != `SEL_3WIRE);

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);

   mosi_dir_a: assert property (mosi_oe_n_o == ~(en & master))
      else $error("data-out direction wrong");
   miso_float_a: assert property (
      (!en || (selm == `SEL_4WIRE_IN && nss_lvl)) |-> miso_oe_n_o)
      else $error("data-in driven while unselected");
   three_wire_a: assert property (
      (en && !master && selm == `SEL_3WIRE) |->
      (!miso_oe_n_o && miso_o == shreg_r[7]))
      else $error("3-wire slave not driving");
   sel_out_a: assert property (selm[1] |->
      (!nss_oe_n_o && nss_o == selm[0]))
      else $error("select output level wrong");
   sel_input_a: assert property ((selm == `SEL_4WIRE_IN) |->
      (nss_oe_n_o && nss_routed_o))
      else $error("select not an input");
   sel_unused_a: assert property ((selm == `SEL_3WIRE) |->
      (nss_oe_n_o && !nss_routed_o))
      else $error("select routed in 3-wire");
   mode_fault_a: assert property (
      (en && master && selm == `SEL_4WIRE_IN && nss_fall) |=>
      (!en && !master && ctrl_r[`CTRL_MODE_FAULT_FLAG_BIT]))
      else $error("mode fault missed");
   ignore_sck_a: assert property (
      (en && !master && selm == `SEL_4WIRE_IN && nss_lvl && !nss_fall
       && !wr_i) |=> $stable(shreg_r))
      else $error("clock not ignored");
   cnt_reset_a: assert property (
      (en && !master && selm == `SEL_4WIRE_IN && nss_fall) |=>
      bcnt_r == 4'h0)
      else $error("bit counter not reset");
   idle_off_a: assert property (!en |=> mst_r == spi_pins_pkg::M_IDLE)
      else $error("disabled port busy");
   sck_idle_a: assert property (
      (mst_r == spi_pins_pkg::M_IDLE) |-> !sck_r)
      else $error("serial clock left high while idle");

   mst_byte_c: cover property (mst_r == spi_pins_pkg::M_BUSY ##1
      mst_r == spi_pins_pkg::M_IDLE);
   mode_fault_flag_c: cover property ($rose(ctrl_r[`CTRL_MODE_FAULT_FLAG_BIT]));
   slv_byte_c: cover property (!master && $rose(ctrl_r[`CTRL_DONE_BIT]));
   // Byte received as an always-selected slave
   three_wire_c: cover property (en && !master && selm == `SEL_3WIRE
      && $rose(ctrl_r[`CTRL_DONE_BIT]));

endmodule : spi_pin_sel
`default_nettype wire

// ---- hw/spi_pins_defines.svh ----
// Constants for the serial port pin and select mode logic.
// Assumes inclusion by bare name from the design files.
`ifndef SPI_PINS_DEFINES_SVH
`define SPI_PINS_DEFINES_SVH

// Register map (word addresses on the plain register port)
`define ADDR_CTRL        4'h0
`define ADDR_DATA        4'h1
`define ADDR_CLKDIV      4'h2
// Control register fields
`define CTRL_EN_BIT      0
`define CTRL_SELLO_BIT   2
`define CTRL_SELHI_BIT   3
`define CTRL_MODE_FAULT_FLAG_BIT    5
`define CTRL_MASTER_ENABLE_BIT_BIT   6
`define CTRL_DONE_BIT    7
`define CTRL_RESET       8'h04
// Select mode encodings
`define SEL_3WIRE        2'b00
`define SEL_4WIRE_IN     2'b01
// Master clock half period less one, default in system clocks
`define CLKDIV_RESET     8'h03
`define BITS_PER_BYTE    4'h8

`endif

// ---- hw/spi_pins_pkg.sv ----
// Types for the serial port pin and select mode logic.
// Assumes the defines header is compiled alongside.
`default_nettype none
package spi_pins_pkg;
   typedef enum logic [1:0] {
      MODE_3WIRE,
      MODE_4WIRE_IN,
      MODE_OUT_LO,
      MODE_OUT_HI
   } sel_mode_t;
   typedef enum logic {
      M_IDLE,
      M_BUSY
   } mst_state_t;
endpackage : spi_pins_pkg
`default_nettype wire

// ---- tb/spi_far_end.sv ----
// Far-side serial device model: master or slave, mode 0 clocking.
// Assumes the bench resolves the shared lines and supplies clk_i.
`default_nettype none

module spi_far_end (
   // Bench clock
   input  wire logic clk_i,
   // Resolved bus lines
   input  wire logic sck_i,
   input  wire logic mosi_i,
   input  wire logic miso_i,
   // Model drive
   output logic      sck_o,
   output logic      data_o,
   output logic      nss_o,
   output logic      mst_o
);
   timeunit 1ns;
   timeprecision 1ps;

   logic [7:0] tx_r = 8'h00;
   logic [7:0] rx_r = 8'h00;

   // Idle: slave role, select high, clock low
   initial begin
      sck_o = 1'b0;
      nss_o = 1'b1;
      mst_o = 1'b0;
   end

   // Top bit drives data-out as master, data-in as slave
   assign data_o = tx_r[7];

   // Sample the other party on rise, shift on fall
   always @(posedge sck_i) rx_r <= {rx_r[6:0], mst_o ? miso_i : mosi_i};
   always @(negedge sck_i) tx_r <= {tx_r[6:0], 1'b0};

   // Pick role and preload the shift register
   task automatic load(input logic mst, input logic [7:0] b);
      mst_o <= mst;
      tx_r <= b;
      @(posedge clk_i);
   endtask : load

   // Select, then settle well before any clock edge
   task automatic select(input logic lvl);
      nss_o <= lvl;
      repeat (4) @(posedge clk_i);
   endtask : select

   // Serial clock for n bits, selected or not, 80 ns period
   task automatic clock_bits(input int n);
      repeat (n) begin
         repeat (8) @(posedge clk_i);
         sck_o <= 1'b1;
         repeat (8) @(posedge clk_i);
         sck_o <= 1'b0;
      end
      repeat (8) @(posedge clk_i);
   endtask : clock_bits
endmodule : spi_far_end

`default_nettype wire

// ---- tb/spi_pin_sel_tb.sv ----
// Self-checking bench for the serial port pin and select logic.
// Assumes the far-side model and design files are compiled first.
`include "spi_pins_defines.svh"
`default_nettype none

module spi_pin_sel_tb;
   timeunit 1ns;
   timeprecision 1ps;

   logic       clk_i;
   logic       sys_rst_i;
   logic [3:0] addr_i;
   logic [7:0] wdata_i;
   logic       wr_i;
   logic       rd_i;
   logic [7:0] rdata_o;
   logic [7:0] d;
   logic       mosi_o, mosi_oe_n_o, miso_o, miso_oe_n_o, sck_o, sck_oe_n_o;
   logic       nss_o, nss_oe_n_o, nss_routed_o;
   logic       f_sck, f_data, f_nss, f_mst, sck_w, mosi_w, miso_w, nss_w;
   int         fail_count = 0;
   int         samples_checked = 0;
   int         cycles = 0;

   // 200 MHz clock
   always #2.5 clk_i = ~clk_i;

   // Wired lines; undriven lines rest at their pull-up level
   assign sck_w = !sck_oe_n_o ? sck_o : (f_mst ? f_sck : 1'b1);
   assign mosi_w = !mosi_oe_n_o ? mosi_o : (f_mst ? f_data : 1'b1);
   assign miso_w = !miso_oe_n_o ? miso_o : (!f_mst ? f_data : 1'b1);
   assign nss_w = !nss_oe_n_o ? nss_o : f_nss;

   spi_pin_sel u_spi_pin_sel (
      .clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .addr_i(addr_i), .wdata_i(wdata_i),
      .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe_n_o(mosi_oe_n_o),
      .miso_i(miso_w), .miso_o(miso_o), .miso_oe_n_o(miso_oe_n_o),
      .sck_i(sck_w), .sck_o(sck_o), .sck_oe_n_o(sck_oe_n_o),
      .nss_i(nss_w), .nss_o(nss_o), .nss_oe_n_o(nss_oe_n_o),
      .nss_routed_o(nss_routed_o));

   spi_far_end u_spi_far_end (
      .clk_i(clk_i), .sck_i(sck_w), .mosi_i(mosi_w), .miso_i(miso_w),
      .sck_o(f_sck), .data_o(f_data), .nss_o(f_nss), .mst_o(f_mst));

   // Compare and count
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk

   // Register write, then let the pins settle
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      addr_i <= a;
      wdata_i <= v;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : wr

   // Register read; data stand in the following cycle only
   task automatic rd(input logic [3:0] a);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      @(negedge clk_i);
      d = rdata_o;
      @(posedge clk_i);
   endtask : rd

   // Pin drive pattern: mosi, miso, sck, select enables, level, routing
   task automatic pins(input logic [7:0] exp);
      @(negedge clk_i);
      chk({2'b00, mosi_oe_n_o, miso_oe_n_o, sck_oe_n_o, nss_oe_n_o,
           nss_o | nss_oe_n_o, nss_routed_o}, exp);
      @(posedge clk_i);
   endtask : pins

   // Poll for byte done, bounded
   task automatic wait_done;
      for (int i = 0; i < 200; i++) begin
         rd(`ADDR_CTRL);
         if (d[`CTRL_DONE_BIT] === 1'b1) break;
      end
   endtask : wait_done

   task automatic t_reset;
      rd(`ADDR_CTRL);
      chk(d, `CTRL_RESET);
      rd(`ADDR_CLKDIV);
      chk(d, `CLKDIV_RESET);
      rd(4'hf);
      chk(d, 8'h00);
   endtask : t_reset

   task automatic t_disabled;
      u_spi_far_end.load(1'b1, 8'hff);
      u_spi_far_end.select(1'b0);
      u_spi_far_end.clock_bits(8);
      pins(8'h3f);
      u_spi_far_end.select(1'b1);
      rd(`ADDR_CTRL);
      chk(d, 8'h04);
   endtask : t_disabled

   task automatic t_master3;
      wr(`ADDR_CTRL, 8'h41);
      pins(8'h16);
      u_spi_far_end.load(1'b0, 8'h3c);
      wr(`ADDR_DATA, 8'ha5);
      wait_done;
      rd(`ADDR_DATA);
      chk(d, 8'h3c);
      chk(u_spi_far_end.rx_r, 8'ha5);
   endtask : t_master3

   // Select as output, high then low level, with master role
   task automatic t_master_out;
      wr(`ADDR_CTRL, 8'h4d);
      pins(8'h13);
      wr(`ADDR_CTRL, 8'h49);
      pins(8'h11);
   endtask : t_master_out

   task automatic t_fault;
      wr(`ADDR_CTRL, 8'h45);
      pins(8'h17);
      u_spi_far_end.select(1'b0);
      rd(`ADDR_CTRL);
      chk(d, 8'h24);
      pins(8'h3f);
      u_spi_far_end.select(1'b1);
   endtask : t_fault

   task automatic t_slave4;
      u_spi_far_end.load(1'b1, 8'h00);
      wr(`ADDR_CTRL, 8'h05);
      u_spi_far_end.clock_bits(8);
      rd(`ADDR_CTRL);
      chk(d, 8'h05);
      pins(8'h3f);
      u_spi_far_end.select(1'b0);
      u_spi_far_end.clock_bits(3);
      u_spi_far_end.select(1'b1);
      wr(`ADDR_DATA, 8'h5a);
      u_spi_far_end.load(1'b1, 8'h96);
      u_spi_far_end.select(1'b0);
      pins(8'h2f);
      u_spi_far_end.clock_bits(8);
      wait_done;
      u_spi_far_end.select(1'b1);
      rd(`ADDR_DATA);
      chk(d, 8'h96);
      chk(u_spi_far_end.rx_r, 8'h5a);
   endtask : t_slave4

   task automatic t_slave3;
      wr(`ADDR_CTRL, 8'h01);
      pins(8'h2e);
      u_spi_far_end.load(1'b1, 8'h00);
      u_spi_far_end.clock_bits(3);
      wr(`ADDR_CTRL, 8'h00);
      wr(`ADDR_CTRL, 8'h01);
      rd(`ADDR_CTRL);
      chk(d, 8'h01);
      wr(`ADDR_DATA, 8'h81);
      u_spi_far_end.load(1'b1, 8'h7e);
      u_spi_far_end.clock_bits(8);
      wait_done;
      rd(`ADDR_DATA);
      chk(d, 8'h7e);
      chk(u_spi_far_end.rx_r, 8'h81);
   endtask : t_slave3

   // Counts, verdict and end of run
   task automatic wrap_up;
      $display("checks %0d, mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : wrap_up

   // Hang guard
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         fail_count++;
         wrap_up;
      end
   end

   // Main sequence
   initial begin
      clk_i = 1'b0;
      sys_rst_i <= 1'b1;
      addr_i <= 4'h0;
      wdata_i <= 8'h00;
      wr_i <= 1'b0;
      rd_i <= 1'b0;
      repeat (8) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      t_reset;
      pins(8'h3f);
      t_disabled;
      t_master3;
      t_master_out;
      t_fault;
      t_slave4;
      t_slave3;
      wrap_up;
   end
endmodule : spi_pin_sel_tb

`default_nettype wire
